// File: design/amp_ctrl.sv
// Notes on behaviour
// - Every phase counts whole system clock cycles.
// - Read lasts setup plus strobe plus hold.
// - Extended read adds sixteen cycles per unit.
// - Write lasts setup plus strobe plus hold.
// - Extended write adds sixteen cycles per unit.
// - Read strobe low for programmed strobe cycles.
// - Extended read strobe stretched sixteen per unit.
// - Read address valid setup cycles before strobe.
// - Read address held hold cycles after strobe.
// - Read select leads/trails strobe, or tracks it.
// - Write address valid setup cycles before strobe.
// - Write address held hold cycles after strobe.
// - Write select leads/trails strobe, or tracks it.
// - Timely wait prolongs strobe until wait releases.
// - Strobe rises four cycles after wait release.
// - Setup, strobe, hold and turnaround counts come from software registers; the release count is fixed.
// - Wait extension bounded by maximum, then timeout.
// - Extended write strobe stretched sixteen per unit.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
module amp_ctrl
  import amp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_wait_input,
  input wire logic [15:0] ext_data_in,
  output amp_pins_type pins
);

  // ----------------------------------------------------------------
  // Registers and state.
  // ----------------------------------------------------------------
  logic extended_wait_enable;
  logic select_strobe_mode;
  amp_timing_type timing;
  logic [7:0] max_ext_wait_cycles;
  logic [25:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic done_flag;
  logic timeout_flag;
  logic [7:0] ext_wait_count;
  logic [3:0] unit_count;
  logic op_write;
  logic wait_armed;
  logic wait_sync;
  logic [15:0] data_sync;
  logic capture_pending;
  amp_state_type state;
  amp_state_type next_state;
  logic timer_load;
  logic [7:0] timer_value;
  logic [7:0] remaining;
  logic last;
  logic bus_write;
  logic start_read;
  logic start_write;
  logic go_extend;
  logic timeout_now;
  logic strobe_end;
  logic access_end;

  // ----------------------------------------------------------------
  // APB slave.
  // ----------------------------------------------------------------

  // One wait state on every transfer so prdata can come from a flop.
  assign bus_write = psel && penable && pready && pwrite;
  assign start_read = bus_write && (paddr == AMP_CMD_OFFSET) && pwdata[AMP_CMD_READ_BIT]
                      && (state == AMP_IDLE);
  assign start_write = bus_write && (paddr == AMP_CMD_OFFSET) && pwdata[AMP_CMD_WRITE_BIT]
                       && !pwdata[AMP_CMD_READ_BIT] && (state == AMP_IDLE);

  // Ready, read data and error answer are all registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready) begin
        if (paddr == AMP_CTRL_OFFSET) begin
          prdata[AMP_CTRL_EXT_WAIT_BIT] <= extended_wait_enable;
          prdata[AMP_CTRL_SEL_STROBE_BIT] <= select_strobe_mode;
        end else if (paddr == AMP_TIMING_OFFSET) begin
          prdata <= timing;
        end else if (paddr == AMP_WAITCFG_OFFSET) begin
          prdata[7:0] <= max_ext_wait_cycles;
        end else if (paddr == AMP_ADDR_OFFSET) begin
          prdata[25:0] <= addr_reg;
        end else if (paddr == AMP_WDATA_OFFSET) begin
          prdata[15:0] <= wdata_reg;
        end else if (paddr == AMP_CMD_OFFSET) begin
          prdata <= 32'h0000_0000;
        end else if (paddr == AMP_STATUS_OFFSET) begin
          prdata[AMP_STATUS_BUSY_BIT] <= (state != AMP_IDLE);
          prdata[AMP_STATUS_DONE_BIT] <= done_flag;
          prdata[AMP_STATUS_TIMEOUT_BIT] <= timeout_flag;
          prdata[AMP_STATUS_COUNT_LSB +: 8] <= ext_wait_count;
        end else if (paddr == AMP_RDATA_OFFSET) begin
          prdata[15:0] <= rdata_reg;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Configuration registers; software owns the setup, strobe, hold and turnaround lengths.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      extended_wait_enable <= 1'b0;
      select_strobe_mode <= 1'b0;
      timing <= AMP_TIMING_RESET;
      max_ext_wait_cycles <= AMP_MAX_WAIT_RESET;
      addr_reg <= 26'h000_0000;
      wdata_reg <= 16'h0000;
    end else if (bus_write) begin
      if (paddr == AMP_CTRL_OFFSET) begin
        extended_wait_enable <= pwdata[AMP_CTRL_EXT_WAIT_BIT];
        select_strobe_mode <= pwdata[AMP_CTRL_SEL_STROBE_BIT];
      end else if (paddr == AMP_TIMING_OFFSET) begin
        timing <= pwdata;
      end else if (paddr == AMP_WAITCFG_OFFSET) begin
        max_ext_wait_cycles <= pwdata[7:0];
      end else if (paddr == AMP_ADDR_OFFSET) begin
        addr_reg <= pwdata[25:0];
      end else if (paddr == AMP_WDATA_OFFSET) begin
        wdata_reg <= pwdata[15:0];
      end
    end
  end

  // Sticky status bits are cleared by writing one; a setting event wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag <= 1'b0;
      timeout_flag <= 1'b0;
    end else begin
      if (access_end) begin
        done_flag <= 1'b1;
      end else if (bus_write && (paddr == AMP_STATUS_OFFSET)
                   && pwdata[AMP_STATUS_DONE_BIT]) begin
        done_flag <= 1'b0;
      end
      if (timeout_now) begin
        timeout_flag <= 1'b1;
      end else if (bus_write && (paddr == AMP_STATUS_OFFSET)
                   && pwdata[AMP_STATUS_TIMEOUT_BIT]) begin
        timeout_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin sampling.
  // ----------------------------------------------------------------

  // The wait pin is asynchronous to the system clock.
  amp_sync2 #(
    .WIDTH(1)
  ) wait_sync_inst (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(ext_wait_input),
    .sync_out(wait_sync)
  );

  // ----------------------------------------------------------------
  // Phase sequencer.
  // ----------------------------------------------------------------
  amp_phase_timer #(
    .WIDTH(8)
  ) timer_inst (
    .pclk(pclk),
    .presetn(presetn),
    .load(timer_load),
    .load_value(timer_value),
    .remaining(remaining),
    .last(last)
  );

  // Extension is taken when the wait was seen early enough in the strobe or is still seen on its last cycle.
  assign go_extend = (state == AMP_STROBE) && last && extended_wait_enable
                     && (wait_armed || wait_sync);
  assign timeout_now = (state == AMP_EXTEND) && wait_sync && (unit_count == AMP_UNIT_LAST)
                       && ((ext_wait_count + 8'h01) >= max_ext_wait_cycles);
  assign strobe_end = ((state == AMP_STROBE) && last && !go_extend)
                      || ((state == AMP_RELEASE) && last) || timeout_now;
  assign access_end = (state == AMP_HOLD) && last;

  // Next state and the phase length to load on entry.
  always_comb begin
    next_state = state;
    timer_load = 1'b0;
    timer_value = 8'h00;
    case (state)
      AMP_IDLE: begin
        if (start_read || start_write) begin
          next_state = AMP_SETUP;
          timer_load = 1'b1;
          timer_value = start_write ? 8'(timing.write_setup_cycles)
                                    : 8'(timing.read_setup_cycles);
        end
      end
      AMP_SETUP: begin
        if (last) begin
          next_state = AMP_STROBE;
          timer_load = 1'b1;
          timer_value = op_write ? 8'(timing.write_strobe_cycles)
                                 : 8'(timing.read_strobe_cycles);
        end
      end
      AMP_STROBE: begin
        if (go_extend) begin
          next_state = AMP_EXTEND;
        end else if (last) begin
          next_state = AMP_HOLD;
          timer_load = 1'b1;
          timer_value = op_write ? 8'(timing.write_hold_cycles)
                                 : 8'(timing.read_hold_cycles);
        end
      end
      AMP_EXTEND: begin
        if (timeout_now) begin
          next_state = AMP_HOLD;
          timer_load = 1'b1;
          timer_value = op_write ? 8'(timing.write_hold_cycles)
                                 : 8'(timing.read_hold_cycles);
        end else if (!wait_sync) begin
          next_state = AMP_RELEASE;
          timer_load = 1'b1;
          timer_value = AMP_RELEASE_COUNT;
        end
      end
      AMP_RELEASE: begin
        if (last) begin
          next_state = AMP_HOLD;
          timer_load = 1'b1;
          timer_value = op_write ? 8'(timing.write_hold_cycles)
                                 : 8'(timing.read_hold_cycles);
        end
      end
      AMP_HOLD: begin
        if (last) begin
          if (timing.turnaround_cycles != 2'b00) begin
            next_state = AMP_TURN;
            timer_load = 1'b1;
            timer_value = 8'(timing.turnaround_cycles);
          end else begin
            next_state = AMP_IDLE;
          end
        end
      end
      AMP_TURN: begin
        if (last) begin
          next_state = AMP_IDLE;
        end
      end
      default: begin
        next_state = AMP_IDLE;
      end
    endcase
  end

  // Phase register; each phase but idle and extension ends when its cycle count runs out.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= AMP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Direction of the access in flight.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_write <= 1'b0;
    end else if (state == AMP_IDLE) begin
      op_write <= start_write;
    end
  end

  // A wait seen with at least the setup margin left arms the extension;
  // the margin excludes the synchroniser delay, so the pin needs four periods.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_armed <= 1'b0;
    end else if (state != AMP_STROBE) begin
      wait_armed <= 1'b0;
    end else if (wait_sync && (remaining >= AMP_ARM_LEFT)) begin
      wait_armed <= 1'b1;
    end
  end

  // Extension is counted in units of sixteen cycles, reported in status.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_count <= 4'h0;
      ext_wait_count <= 8'h00;
    end else if (go_extend) begin
      unit_count <= 4'h0;
      ext_wait_count <= 8'h00;
    end else if (state == AMP_EXTEND) begin
      unit_count <= unit_count + 4'h1;
      if (unit_count == AMP_UNIT_LAST) begin
        ext_wait_count <= ext_wait_count + 8'h01;
      end
    end
  end

  // Read data: a capture flop on the strobe's last edge, then a second flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_sync <= 16'h0000;
      capture_pending <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      capture_pending <= strobe_end && !op_write;
      if (strobe_end && !op_write) begin
        data_sync <= ext_data_in;
      end
      if (capture_pending) begin
        rdata_reg <= data_sync;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory pins, all registered from the next phase.
  // ----------------------------------------------------------------

  // Address and bank stay put from setup through hold; they change only on a start.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins.ext_address <= 21'h00_0000;
      pins.bank_address <= 2'h0;
      pins.ext_data_out <= 16'h0000;
    end else if (start_read || start_write) begin
      pins.ext_address <= addr_reg[20:0];
      pins.bank_address <= addr_reg[AMP_ADDR_BANK_LSB +: 2];
      pins.ext_data_out <= wdata_reg;
    end
  end

  // Strobes low through strobe, extension and release; select per mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins.chip_select_n <= 4'hF;
      pins.read_strobe_n <= 1'b1;
      pins.write_strobe_n <= 1'b1;
      pins.ext_data_oe_n <= 1'b1;
    end else begin
      pins.read_strobe_n <= 1'b1;
      pins.write_strobe_n <= 1'b1;
      pins.chip_select_n <= 4'hF;
      pins.ext_data_oe_n <= 1'b1;
      if ((next_state == AMP_STROBE) || (next_state == AMP_EXTEND)
          || (next_state == AMP_RELEASE)) begin
        if (next_op_write()) begin
          pins.write_strobe_n <= 1'b0;
        end else begin
          pins.read_strobe_n <= 1'b0;
        end
        pins.chip_select_n[addr_reg[AMP_ADDR_CS_LSB +: 2]] <= 1'b0;
      end else if (((next_state == AMP_SETUP) || (next_state == AMP_HOLD))
                   && !select_strobe_mode) begin
        pins.chip_select_n[addr_reg[AMP_ADDR_CS_LSB +: 2]] <= 1'b0;
      end
      if ((next_state != AMP_IDLE) && (next_state != AMP_TURN) && next_op_write()) begin
        pins.ext_data_oe_n <= 1'b0;
      end
    end
  end

  // Direction as it will be after this edge, including the starting cycle.
  function automatic logic next_op_write();
    next_op_write = (state == AMP_IDLE) ? start_write : op_write;
  endfunction : next_op_write

endmodule : amp_ctrl

// File: design/amp_phase_timer.sv
module amp_phase_timer
  import amp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic [WIDTH-1:0] remaining,
  output logic last
);

  // A phase programmed as zero still lasts one cycle, so the state machine never stalls.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remaining <= '0;
    end else if (load) begin
      remaining <= (load_value == '0) ? WIDTH'(1) : load_value;
    end else if (remaining != '0) begin
      remaining <= remaining - WIDTH'(1);
    end
  end

  assign last = (remaining == WIDTH'(1));

endmodule : amp_phase_timer

// File: design/amp_pkg.sv
package amp_pkg;

  // ----------------------------------------------------------------
  // Register map, byte addresses on the APB side.
  // ----------------------------------------------------------------
  localparam logic [7:0] AMP_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] AMP_TIMING_OFFSET = 8'h04;
  localparam logic [7:0] AMP_WAITCFG_OFFSET = 8'h08;
  localparam logic [7:0] AMP_ADDR_OFFSET = 8'h0C;
  localparam logic [7:0] AMP_WDATA_OFFSET = 8'h10;
  localparam logic [7:0] AMP_CMD_OFFSET = 8'h14;
  localparam logic [7:0] AMP_STATUS_OFFSET = 8'h18;
  localparam logic [7:0] AMP_RDATA_OFFSET = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int AMP_CTRL_EXT_WAIT_BIT = 0;
  localparam int AMP_CTRL_SEL_STROBE_BIT = 1;
  localparam int AMP_CMD_READ_BIT = 0;
  localparam int AMP_CMD_WRITE_BIT = 1;
  localparam int AMP_STATUS_BUSY_BIT = 0;
  localparam int AMP_STATUS_DONE_BIT = 1;
  localparam int AMP_STATUS_TIMEOUT_BIT = 2;
  localparam int AMP_STATUS_COUNT_LSB = 8;
  localparam int AMP_ADDR_BANK_LSB = 21;
  localparam int AMP_ADDR_CS_LSB = 24;

  // ----------------------------------------------------------------
  // Timing register layout and reset values.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] spare;
    logic [1:0] turnaround_cycles;
    logic [2:0] write_hold_cycles;
    logic [5:0] write_strobe_cycles;
    logic [3:0] write_setup_cycles;
    logic [2:0] read_hold_cycles;
    logic [5:0] read_strobe_cycles;
    logic [3:0] read_setup_cycles;
  } amp_timing_type;

  localparam logic [31:0] AMP_TIMING_RESET = 32'h0462_2C21;
  localparam logic [7:0] AMP_MAX_WAIT_RESET = 8'h80;

  // ----------------------------------------------------------------
  // Wait input timing, in system clock periods.
  // ----------------------------------------------------------------
  localparam int AMP_SYNC_STAGES = 2;
  localparam int AMP_WAIT_SETUP_PERIODS = 4;
  localparam int AMP_WAIT_RELEASE_PERIODS = 4;
  localparam int AMP_WAIT_UNIT_PERIODS = 16;
  localparam logic [7:0] AMP_ARM_LEFT = 8'(AMP_WAIT_SETUP_PERIODS - AMP_SYNC_STAGES);
  localparam logic [7:0] AMP_RELEASE_COUNT = 8'(AMP_WAIT_RELEASE_PERIODS - AMP_SYNC_STAGES);
  localparam logic [3:0] AMP_UNIT_LAST = 4'(AMP_WAIT_UNIT_PERIODS - 1);

  // ----------------------------------------------------------------
  // Pins toward the memory.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] chip_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [1:0] bank_address;
    logic [20:0] ext_address;
    logic [15:0] ext_data_out;
    logic ext_data_oe_n;
  } amp_pins_type;

  typedef enum {
    AMP_IDLE,
    AMP_SETUP,
    AMP_STROBE,
    AMP_EXTEND,
    AMP_RELEASE,
    AMP_HOLD,
    AMP_TURN
  } amp_state_type;

endpackage : amp_pkg

// File: design/amp_sync2.sv
module amp_sync2
  import amp_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // Two flops; only the second stage is visible to other logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule : amp_sync2

// File: sim/amp_chk.sv
module amp_chk
  import amp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic ext_wait_input,
  input wire amp_pins_type pins
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  amp_timing_type tim;
  logic ew, ss, wr, cs_on, st_on;
  logic [7:0] cs_cnt, st_cnt, hd_cnt, id_cnt;

  assign cs_on = pins.chip_select_n != 4'hF;
  assign st_on = !pins.read_strobe_n || !pins.write_strobe_n;

  function automatic int eff(input int v);
    return (v == 0) ? 1 : v;
  endfunction : eff

  // ----------------------------------------------------------------
  // Shadow of the settings, taken from completed writes.
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tim <= amp_timing_type'(AMP_TIMING_RESET);
      {ss, ew} <= 2'b00;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == AMP_TIMING_OFFSET) tim <= amp_timing_type'(pwdata);
      if (paddr == AMP_CTRL_OFFSET) {ss, ew} <= pwdata[1:0];
    end
  end

  // Phase counters; the idle count saturates so a long gap never wraps.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_cnt <= 8'h00;
      st_cnt <= 8'h00;
      hd_cnt <= 8'h00;
      id_cnt <= 8'hFF;
      wr <= 1'b0;
    end else begin
      cs_cnt <= cs_on ? cs_cnt + 8'h01 : 8'h00;
      st_cnt <= st_on ? st_cnt + 8'h01 : 8'h00;
      hd_cnt <= (cs_on && !st_on) ? hd_cnt + 8'h01 : 8'h00;
      id_cnt <= cs_on ? 8'h00 : id_cnt + {7'h00, id_cnt != 8'hFF};
      if (!pins.write_strobe_n) wr <= 1'b1;
      else if (!pins.read_strobe_n) wr <= 1'b0;
    end
  end

  a_rd_setup: assert property (
    $fell(pins.read_strobe_n) && !ss |-> cs_cnt == eff(tim.read_setup_cycles))
    else $error("read setup length wrong");
  a_wr_setup: assert property (
    $fell(pins.write_strobe_n) && !ss |-> cs_cnt == eff(tim.write_setup_cycles))
    else $error("write setup length wrong");
  a_rd_strobe: assert property (
    $rose(pins.read_strobe_n) && !ew |-> st_cnt == eff(tim.read_strobe_cycles))
    else $error("read strobe length wrong");
  a_wr_strobe: assert property (
    $rose(pins.write_strobe_n) && !ew |-> st_cnt == eff(tim.write_strobe_cycles))
    else $error("write strobe length wrong");
  a_hold_trail: assert property (
    $fell(cs_on) && !ss |->
      hd_cnt == eff(wr ? tim.write_hold_cycles : tim.read_hold_cycles))
    else $error("hold length wrong");
  a_cycle_len: assert property (
    $fell(cs_on) && !ss && !ew |-> cs_cnt == (wr ?
      eff(tim.write_setup_cycles) + eff(tim.write_strobe_cycles) + eff(tim.write_hold_cycles) :
      eff(tim.read_setup_cycles) + eff(tim.read_strobe_cycles) + eff(tim.read_hold_cycles)))
    else $error("access length wrong");
  a_sel_track: assert property (
    ss |-> cs_on == st_on)
    else $error("select not tracking strobe");
  a_addr_stable: assert property (
    cs_on && $past(cs_on) |-> $stable(pins.ext_address) && $stable(pins.bank_address))
    else $error("address moved during access");
  a_turn_idle: assert property (
    $rose(cs_on) |-> id_cnt >= tim.turnaround_cycles)
    else $error("turnaround too short");
  a_wait_release: assert property (
    $fell(ext_wait_input) && ew && !pins.read_strobe_n &&
      st_cnt > eff(tim.read_strobe_cycles) + 1 |-> ##[4:5] $rose(pins.read_strobe_n))
    else $error("strobe not ended after wait release");
endmodule : amp_chk

// File: sim/amp_mem_model.sv
module amp_mem_model
  import amp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire amp_pins_type pins,
  input wire logic [7:0] wait_len,
  output logic [15:0] ext_data_in,
  output logic ext_wait_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [64];
  logic [15:0] last;
  logic [7:0] wcnt;
  logic st_prev, st_on, rd_on;

  assign st_on = !pins.read_strobe_n || !pins.write_strobe_n;
  assign rd_on = !pins.read_strobe_n && pins.chip_select_n != 4'hF;
  // Undriven bus flips every cycle so stale data can never pass as valid.
  assign ext_data_in = rd_on ? mem[pins.ext_address[5:0]] : ~last;
  // Wait rises one cycle into the strobe, well ahead of its end.
  assign ext_wait_input = wcnt != 8'h00;

  // Writes land only while the block drives the bus; wait length on the system clock.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= 16'h0000;
      wcnt <= 8'h00;
      st_prev <= 1'b0;
    end else begin
      last <= ext_data_in;
      st_prev <= st_on;
      if (wcnt != 8'h00) wcnt <= wcnt - 8'h01;
      else if (st_on && !st_prev) wcnt <= wait_len;
      if (!pins.write_strobe_n && !pins.ext_data_oe_n)
        mem[pins.ext_address[5:0]] <= pins.ext_data_out;
    end
  end
endmodule : amp_mem_model

// File: sim/tb.sv
module tb
  import amp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ext_wait_input, err;
  logic [15:0] ext_data_in;
  logic [7:0] wait_len = 8'h00;
  logic [5:0] cs_seen;
  amp_pins_type pins;
  int bad_count = 0, total_checks = 0;
  int cl = 0, sl = 0, cs_len = 0, st_len = 0;

  amp_ctrl u_amp_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_wait_input, .ext_data_in, .pins);
  amp_mem_model u_amp_mem_model (.pclk, .presetn, .pins, .wait_len, .ext_data_in,
    .ext_wait_input);

  always #5 pclk = ~pclk;

  // Measure select and strobe low time of each access, and note bank and select used.
  always @(posedge pclk) begin
    if (pins.chip_select_n != 4'hF) begin
      cl <= cl + 1;
      cs_seen <= {pins.bank_address, pins.chip_select_n};
    end else if (cl != 0) begin
      cs_len <= cl;
      cl <= 0;
    end
    if (!pins.read_strobe_n || !pins.write_strobe_n) begin
      sl <= sl + 1;
    end else if (sl != 0) begin
      st_len <= sl;
      sl <= 0;
    end
  end

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  function automatic int e1(input int v);
    return (v == 0) ? 1 : v;
  endfunction : e1

  function automatic int st_exp(input amp_timing_type t, input logic w);
    return e1(w ? t.write_strobe_cycles : t.read_strobe_cycles);
  endfunction : st_exp

  function automatic int cs_exp(input amp_timing_type t, input logic w, input logic ss);
    if (ss) return st_exp(t, w);
    if (w) return e1(t.write_setup_cycles) + st_exp(t, w) + e1(t.write_hold_cycles);
    return e1(t.read_setup_cycles) + st_exp(t, w) + e1(t.read_hold_cycles);
  endfunction : cs_exp

  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request held until pready is sampled high at a rising edge; answer taken there.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 40 && pready !== 1'b1; n++) @(posedge pclk);
    if (pready !== 1'b1) begin
      chk("pready_wait", 32'h1, 32'h0);
      print_verdict();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Start one access and wait for done; clears done and timeout after.
  task automatic access(input logic w, output logic [31:0] st);
    int n;
    logic [31:0] q;
    apb(1'b1, AMP_CMD_OFFSET, w ? 32'h2 : 32'h1, q);
    st = 32'h0;
    for (n = 0; n < 300 && st[AMP_STATUS_DONE_BIT] !== 1'b1; n++)
      apb(1'b0, AMP_STATUS_OFFSET, 32'h0, st);
    if (st[AMP_STATUS_DONE_BIT] !== 1'b1) begin
      chk("done_wait", 32'h1, 32'h0);
      print_verdict();
    end
    apb(1'b1, AMP_STATUS_OFFSET, 32'h6, q);
  endtask : access

  initial begin
    logic [31:0] q, st;
    logic [15:0] r;
    amp_timing_type t;
    r = 16'h8B83;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, AMP_TIMING_OFFSET, 32'h0, q);
    chk("timing_reset", AMP_TIMING_RESET, q);
    apb(1'b0, AMP_WAITCFG_OFFSET, 32'h0, q);
    chk("wait_reset", {24'h0, AMP_MAX_WAIT_RESET}, q);
    apb(1'b0, 8'h20, 32'h0, q);
    chk("unmapped_err", 32'h1, {31'h0, err});
    // Random timings; first all zero, second all at maximum.
    for (int i = 0; i < 8; i++) begin
      r = lfsr(r);
      t = amp_timing_type'({r, lfsr(r)});
      if (i == 0) t = '0;
      if (i == 1) t = '1;
      t.spare = 4'h0;
      r = lfsr(lfsr(r));
      apb(1'b1, AMP_TIMING_OFFSET, 32'(t), q);
      apb(1'b1, AMP_CTRL_OFFSET, {30'h0, i[0], 1'b0}, q);
      apb(1'b1, AMP_ADDR_OFFSET, {6'h0, r[1:0], 1'b0, r[3:2], 5'h0, r}, q);
      apb(1'b1, AMP_WDATA_OFFSET, {16'h0, ~r}, q);
      for (int w = 1; w >= 0; w--) begin
        access(w[0], st);
        chk("cs_len", cs_exp(t, w[0], i[0]), cs_len);
        chk("strobe_len", st_exp(t, w[0]), st_len);
        chk("cs_bank", {26'h0, r[3:2], ~(4'h1 << r[1:0])}, {26'h0, cs_seen});
      end
      apb(1'b0, AMP_RDATA_OFFSET, 32'h0, q);
      chk("rdata", {16'h0, ~r}, q);
    end
    // Extended strobe, write then read, released by the memory.
    t = '0;
    t.read_strobe_cycles = 6'h08;
    t.write_strobe_cycles = 6'h08;
    apb(1'b1, AMP_TIMING_OFFSET, 32'(t), q);
    apb(1'b1, AMP_CTRL_OFFSET, 32'h1, q);
    apb(1'b1, AMP_WAITCFG_OFFSET, 32'hFF, q);
    wait_len <= 8'h28;
    for (int w = 1; w >= 0; w--) begin
      access(w[0], st);
      chk("ext_count", (st_len - 8) / 16, {24'h0, st[15:8]});
      chk("ext_cycle", st_len + 2, cs_len);
    end
    // Wait held far past the limit must end in a timeout.
    apb(1'b1, AMP_WAITCFG_OFFSET, 32'h2, q);
    wait_len <= 8'hC8;
    access(1'b0, st);
    chk("timeout", 32'h1, {31'h0, st[AMP_STATUS_TIMEOUT_BIT]});
    print_verdict();
  end
endmodule : tb

bind amp_ctrl amp_chk u_amp_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .ext_wait_input, .pins);
